// *** design/ccm_clock_ctrl.sv ***
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// (RL1) Writing one to bits 2-31 stops clock
// (RL2) Status bit reads one while clock runs
// (RL3) Enable bit starts oscillator; bypass kept zero
// (RL4) Stable flag rises after start-up time
// (RL5) Bypass uses pin clock, stable immediately
// (RL6) Enable and bypass both zero clear stable
// (RL7) Start-up time is count times 8 slow
// (RL8) Frequency field counts main cycles, 16 slow
// (RL9) Ready bit only after enable, count valid
// (RL10) Divider: 0 none, 1 pass, else divide
// (RL11) Lock rises after lock counter slow cycles
// (RL12) Multiplier zero off, else times value+1
// (RL13) USB divider 1, 2, 4; 11 reserved
// (RL14) Software programs range field per frequency
// (RL15) Source: slow 00, main 01, PLL 11
// (RL16) Prescaler divides by powers of two to 64
// (RL17) Unimplemented peripheral bits have no effect
// (RL18) Stable flag reads one once stabilised
// (RL19) Software never writes reserved codes
// (RL20) New enable restarts measurement, clears ready
module ccm_clock_ctrl #(
  parameter logic [31:0] PERIPH_IMPL = ccm_pkg::PERIPH_IMPL_RST
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire ccm_pkg::ccm_bus_req_t busReq,
  output logic [31:0]               rdData,
  input  wire logic                 slowClkPin,
  input  wire logic                 oscInputPin,
  output logic                      oscOutputPin,
  output logic [31:0]               periphClkEn,
  output logic                      masterClkTick,
  output logic                      usbClkTick
);

  if (PERIPH_IMPL[1:0] != 2'b00) begin : gBadImpl
    $error("Peripheral bits 0 and 1 cannot be implemented");
  end

  // ************************************************************
  // Pin synchronisers and edge ticks
  // ************************************************************
  logic [2:0] slowSync;
  logic [2:0] oscSync;
  logic       slowTick;
  logic       pinTick;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      slowSync <= 3'h0;
      oscSync  <= 3'h0;
    end else begin
      slowSync <= {slowSync[1:0], slowClkPin};
      oscSync  <= {oscSync[1:0], oscInputPin};
    end
  end

  assign slowTick = slowSync[1] & ~slowSync[2];
  assign pinTick  = oscSync[1] & ~oscSync[2];

  // ************************************************************
  // Register write decode
  // ************************************************************
  function automatic logic hit(input ccm_pkg::ccm_bus_req_t r, input logic [7:0] ofs);
    hit = r.wrStb && (r.addr == ofs);
  endfunction

  logic        oscEnable;
  logic        oscillator_bypass;
  logic [7:0]  startupCount;
  logic [7:0]  pllDiv;
  logic [7:0]  lockCounter;
  logic [1:0]  pllRange;
  logic [10:0] pllMultiplier;
  logic [1:0]  usbClockDivider;
  logic [1:0]  masterSourceSelect;
  logic [2:0]  masterPrescaler;
  logic        pllWrite;

  assign pllWrite = hit(busReq, ccm_pkg::PLL_CFG_OFS);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      oscEnable    <= 1'b0;
      oscillator_bypass    <= 1'b0;
      startupCount <= 8'h00;
    end else if (hit(busReq, ccm_pkg::OSC_CTRL_OFS)) begin
      oscEnable    <= busReq.wrData[ccm_pkg::OSC_EN_BIT];   // RL3
      oscillator_bypass    <= busReq.wrData[ccm_pkg::OSC_BYP_BIT];  // RL5
      startupCount <= busReq.wrData[ccm_pkg::STARTUP_LSB +: 8];
    end
  end

  // Range is stored only and read back; no logic or output port of this block uses it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pllDiv          <= 8'h00;
      lockCounter     <= ccm_pkg::LOCKCNT_RST;
      pllRange        <= 2'h0;
      pllMultiplier   <= 11'h000;
      usbClockDivider <= 2'h0;
    end else if (pllWrite) begin
      pllDiv          <= busReq.wrData[ccm_pkg::DIV_LSB +: 8];
      lockCounter     <= {2'b00, busReq.wrData[ccm_pkg::LOCKCNT_LSB +: 6]};
      pllRange        <= busReq.wrData[ccm_pkg::RANGE_LSB +: 2];  // RL14
      pllMultiplier   <= busReq.wrData[ccm_pkg::MUL_LSB +: 11];
      usbClockDivider <= busReq.wrData[ccm_pkg::USB_CLOCK_DIVIDER_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      masterSourceSelect <= 2'h0;
      masterPrescaler    <= 3'h0;
    end else if (hit(busReq, ccm_pkg::MASTER_SEL_OFS)) begin
      masterSourceSelect <= busReq.wrData[ccm_pkg::SRC_LSB +: 2];
      masterPrescaler    <= busReq.wrData[ccm_pkg::MASTER_PRESCALER_LSB +: 3];
    end
  end

  // ************************************************************
  // Peripheral clock gates
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      periphClkEn <= 32'h0000_0000;
    end else if (hit(busReq, ccm_pkg::PERIPH_DIS_OFS)) begin
      periphClkEn <= periphClkEn & ~(busReq.wrData & PERIPH_IMPL);  // RL1 RL17
    end else if (hit(busReq, ccm_pkg::PERIPH_EN_OFS)) begin
      periphClkEn <= periphClkEn | (busReq.wrData & PERIPH_IMPL);   // RL17
    end
  end

  // ************************************************************
  // Main oscillator start-up
  // ************************************************************
  logic        oscEnableDly;
  logic        oscStable;
  logic [10:0] startupLeft;
  logic        enableRise;

  assign enableRise = oscEnable & ~oscEnableDly;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      oscEnableDly <= 1'b0;
      oscOutputPin <= 1'b0;
    end else begin
      oscEnableDly <= oscEnable;
      oscOutputPin <= oscEnable & ~oscillator_bypass;  // RL3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      oscStable   <= 1'b0;
      startupLeft <= 11'h000;
    end else if (oscillator_bypass) begin
      oscStable <= 1'b1;  // RL5
    end else if (!oscEnable) begin
      oscStable <= 1'b0;  // RL6
    end else if (enableRise) begin
      startupLeft <= 11'(startupCount * ccm_pkg::STARTUP_MULT);  // RL7
      oscStable   <= 1'b0;
    end else if (startupLeft == 11'h000) begin
      oscStable <= 1'b1;  // RL4 RL18
    end else if (slowTick) begin
      startupLeft <= startupLeft - 11'h001;  // RL7
    end
  end

  // Oscillator edges count only once the clock is trustworthy
  logic mainTick;
  assign mainTick = pinTick & (oscillator_bypass | (oscEnable & oscStable));

  // ************************************************************
  // Main clock frequency measurement
  // ************************************************************
  logic [15:0] mainFreqCount;
  logic [15:0] measAcc;
  logic [4:0]  windowLeft;
  logic        measActive;
  logic        measurementReady;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mainFreqCount    <= 16'h0000;
      measAcc          <= 16'h0000;
      windowLeft       <= 5'h00;
      measActive       <= 1'b0;
      measurementReady <= 1'b0;
    end else if (!oscEnable) begin
      measActive       <= 1'b0;
      measurementReady <= 1'b0;  // RL9
    end else if (enableRise) begin
      measAcc          <= 16'h0000;  // RL20
      windowLeft       <= 5'(ccm_pkg::MEAS_WINDOW);
      measActive       <= 1'b1;
      measurementReady <= 1'b0;  // RL20
    end else if (measActive) begin
      if (mainTick) begin
        measAcc <= measAcc + 16'h0001;  // RL8
      end
      if (slowTick) begin
        windowLeft <= windowLeft - 5'h01;
        if (windowLeft == 5'h01) begin
          mainFreqCount    <= measAcc + {15'h0000, mainTick};  // RL8
          measActive       <= 1'b0;
          measurementReady <= 1'b1;  // RL9
        end
      end
    end
  end

  // ************************************************************
  // PLL: input divider, multiplier and lock
  // ************************************************************
  logic [7:0]  divCnt;
  logic        divTick;
  logic [11:0] pllCredit;
  logic        pllTick;
  logic [7:0]  lockLeft;
  logic        pllLock;

  // Divided input tick; divider 0 gives nothing, 1 passes
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      divCnt  <= 8'h00;
      divTick <= 1'b0;
    end else begin
      divTick <= 1'b0;
      if (pllDiv == 8'h00) begin
        divCnt <= 8'h00;  // RL10
      end else if (mainTick) begin
        if (divCnt >= pllDiv - 8'h01) begin
          divCnt  <= 8'h00;
          divTick <= 1'b1;  // RL10
        end else begin
          divCnt <= divCnt + 8'h01;
        end
      end
    end
  end

  // Each input period earns multiplier+1 output ticks, spent one per
  // cycle: average rate is exact, spacing bursty, capped at sys_clk
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pllCredit <= 12'h000;
      pllTick   <= 1'b0;
    end else if (pllMultiplier == 11'h000) begin
      pllCredit <= 12'h000;  // RL12
      pllTick   <= 1'b0;
    end else begin
      pllTick <= pllCredit != 12'h000;
      if (divTick) begin
        pllCredit <= pllCredit + {1'b0, pllMultiplier} + 12'h001
                     - {11'h000, pllCredit != 12'h000};  // RL12
      end else if (pllCredit != 12'h000) begin
        pllCredit <= pllCredit - 12'h001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lockLeft <= ccm_pkg::LOCKCNT_RST;
      pllLock  <= 1'b0;
    end else if (pllWrite) begin
      lockLeft <= {2'b00, busReq.wrData[ccm_pkg::LOCKCNT_LSB +: 6]};  // RL11
      pllLock  <= 1'b0;
    end else if (lockLeft == 8'h00) begin
      pllLock <= 1'b1;  // RL11
    end else if (slowTick) begin
      lockLeft <= lockLeft - 8'h01;
    end
  end

  // ************************************************************
  // USB divider and master clock prescaler
  // ************************************************************
  logic [1:0] usbCnt;
  logic [5:0] presCnt;
  logic       srcTick;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      usbCnt     <= 2'h0;
      usbClkTick <= 1'b0;
    end else begin
      usbClkTick <= 1'b0;
      if (pllTick) begin
        usbCnt <= usbCnt + 2'h1;
        case (usbClockDivider)
          2'b00: begin
            usbClkTick <= 1'b1;  // RL13
          end
          2'b01: begin
            usbClkTick <= usbCnt[0];  // RL13
          end
          2'b10: begin
            usbClkTick <= usbCnt == 2'h3;  // RL13
          end
          default: begin
            usbClkTick <= 1'b0;
          end
        endcase
      end
    end
  end

  always_comb begin
    case (ccm_pkg::ccm_src_t'(masterSourceSelect))
      ccm_pkg::SRC_SLOW: srcTick = slowTick;  // RL15
      ccm_pkg::SRC_MAIN: srcTick = mainTick;  // RL15
      ccm_pkg::SRC_PLL:  srcTick = pllTick;   // RL15
      default:           srcTick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      presCnt       <= 6'h00;
      masterClkTick <= 1'b0;
    end else begin
      masterClkTick <= 1'b0;
      if (srcTick && masterPrescaler != 3'h7) begin
        if (presCnt >= 6'((7'h01 << masterPrescaler) - 7'h01)) begin
          presCnt       <= 6'h00;
          masterClkTick <= 1'b1;  // RL16
        end else begin
          presCnt <= presCnt + 6'h01;  // RL16
        end
      end
    end
  end

  // ************************************************************
  // Register read, data one cycle after the strobe
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rdData <= 32'h0000_0000;
    end else if (busReq.rdStb) begin
      case (busReq.addr)
        ccm_pkg::PERIPH_STAT_OFS: rdData <= periphClkEn;  // RL2
        ccm_pkg::OSC_CTRL_OFS: rdData <= {16'h0000, startupCount, 6'h00, oscillator_bypass, oscEnable};
        ccm_pkg::MAIN_FREQ_OFS: rdData <= {15'h0000, measurementReady, mainFreqCount};  // RL8 RL9
        ccm_pkg::PLL_CFG_OFS: rdData <= {2'b00, usbClockDivider, 1'b0, pllMultiplier,
                                         pllRange, lockCounter[5:0], pllDiv};
        ccm_pkg::MASTER_SEL_OFS: rdData <= {27'h000_0000, masterPrescaler, masterSourceSelect};
        ccm_pkg::STATUS_OFS: rdData <= {28'h000_0000, 1'b1, pllLock, 1'b0, oscStable};  // RL18
        default: rdData <= 32'h0000_0000;
      endcase
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

endmodule

// *** design/ccm_pkg.sv ***
package ccm_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] PERIPH_EN_OFS     = 8'h10;
  localparam logic [7:0] PERIPH_DIS_OFS    = 8'h14;
  localparam logic [7:0] PERIPH_STAT_OFS   = 8'h18;
  localparam logic [7:0] OSC_CTRL_OFS      = 8'h20;
  localparam logic [7:0] MAIN_FREQ_OFS     = 8'h24;
  localparam logic [7:0] PLL_CFG_OFS       = 8'h2C;
  localparam logic [7:0] MASTER_SEL_OFS    = 8'h30;
  localparam logic [7:0] STATUS_OFS        = 8'h68;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int OSC_EN_BIT       = 0;
  localparam int OSC_BYP_BIT      = 1;
  localparam int STARTUP_LSB      = 8;
  localparam int FREQ_RDY_BIT     = 16;
  localparam int DIV_LSB          = 0;
  localparam int LOCKCNT_LSB      = 8;
  localparam int RANGE_LSB        = 14;
  localparam int MUL_LSB          = 16;
  localparam int USB_CLOCK_DIVIDER_LSB       = 28;
  localparam int SRC_LSB          = 0;
  localparam int MASTER_PRESCALER_LSB         = 2;
  localparam int STAT_STABLE_BIT  = 0;
  localparam int STAT_LOCK_BIT    = 2;
  localparam int STAT_MRDY_BIT    = 3;

  // ************************************************************
  // Reset values, codes and timing counts
  // ************************************************************
  localparam logic [7:0]  LOCKCNT_RST     = 8'h3F;
  localparam logic [31:0] PERIPH_IMPL_RST = 32'hFFFF_FFFC;
  localparam int          STARTUP_MULT    = 8;
  localparam int          MEAS_WINDOW     = 16;

  typedef enum logic [1:0] {
    SRC_SLOW = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_RSVD = 2'b10,
    SRC_PLL  = 2'b11
  } ccm_src_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wrData;
    logic        wrStb;
    logic        rdStb;
  } ccm_bus_req_t;

endpackage

// *** bench/ccm_clock_ctrl_props.sv ***
`timescale 1ns/10ps
module ccm_clock_ctrl_props (
  input wire logic                  sys_clk,
  input wire logic                  rstn,
  input wire ccm_pkg::ccm_bus_req_t busReq,
  input wire logic [31:0]           rdData,
  input wire logic                  slowClkPin,
  input wire logic                  oscInputPin,
  input wire logic                  oscOutputPin,
  input wire logic [31:0]           periphClkEn,
  input wire logic                  masterClkTick,
  input wire logic                  usbClkTick
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ************************************************************
  // Bus steps
  // ************************************************************
  sequence sqOscWr;
    busReq.wrStb && busReq.addr == ccm_pkg::OSC_CTRL_OFS;
  endsequence
  sequence sqStatRd;
    busReq.rdStb && busReq.addr == ccm_pkg::STATUS_OFS;
  endsequence
  AST_DIS: assert property (busReq.wrStb && busReq.addr == ccm_pkg::PERIPH_DIS_OFS |=>
    periphClkEn == ($past(periphClkEn) & ~$past(busReq.wrData))) else $error("disable bad");
  AST_STAT: assert property (busReq.rdStb && busReq.addr == ccm_pkg::PERIPH_STAT_OFS |=>
    rdData == $past(periphClkEn)) else $error("status read bad");
  AST_LOW: assert property (periphClkEn[1:0] == 2'b00) else $error("bits 1:0 set");
  AST_IDLE: assert property (!busReq.rdStb |=> rdData == 32'h0) else $error("rdData not 0");
  AST_OUT: assert property (sqOscWr |-> ##2
    oscOutputPin == ($past(busReq.wrData[0], 2) && !$past(busReq.wrData[1], 2)))
    else $error("osc drive");
  AST_BYP: assert property (sqOscWr ##0 busReq.wrData[1:0] == 2'b10 ##2 sqStatRd |=>
    rdData[ccm_pkg::STAT_STABLE_BIT]) else $error("bypass not stable");
  AST_CLR: assert property (sqOscWr ##0 busReq.wrData[1:0] == 2'b00 ##2 sqStatRd |=>
    !rdData[ccm_pkg::STAT_STABLE_BIT]) else $error("stable not cleared");
  AST_MRDY: assert property (!oscOutputPin ##0 sqOscWr ##0 busReq.wrData[1:0] == 2'b01
    ##2 busReq.rdStb && busReq.addr == ccm_pkg::MAIN_FREQ_OFS |=>
    !rdData[ccm_pkg::FREQ_RDY_BIT]) else $error("ready not cleared");
  AST_LOCK: assert property (busReq.wrStb && busReq.addr == ccm_pkg::PLL_CFG_OFS
    && busReq.wrData[13:8] > 6'h01 ##2 sqStatRd |=>
    !rdData[ccm_pkg::STAT_LOCK_BIT]) else $error("lock not cleared");
  AST_RSVD: assert property (busReq.wrStb && busReq.addr == ccm_pkg::MASTER_SEL_OFS
    && busReq.wrData[1:0] == 2'b10 |-> ##4 !masterClkTick [*8]) else $error("reserved ticks");
endmodule

// *** bench/ccm_clock_ctrl_bench.sv ***
`timescale 1ns/10ps
module ccm_clock_ctrl_bench;
  // Upper nibble left unimplemented so stray writes there can be seen
  localparam logic [31:0] IMPL = 32'h0FFF_FFFC;
  logic                  sys_clk;
  logic                  rstn;
  ccm_pkg::ccm_bus_req_t busReq;
  logic [31:0]           rdData;
  logic                  slowClkPin;
  logic                  oscInputPin;
  logic                  oscOutputPin;
  logic [31:0]           periphClkEn;
  logic                  masterClkTick;
  logic                  usbClkTick;
  int                    fail_count;
  int                    checks;
  int unsigned           seed;
  int                    pce;
  int                    cyc;
  int                    m;
  int                    u;
  int                    t;
  logic [31:0]           v;
  logic [31:0]           d;
  logic [31:0]           pllTab[8] = '{32'h0001_0302, 32'h1001_0302, 32'h2001_0302,
                                       32'h0001_0301, 32'h0001_0300, 32'h0000_0302,
                                       32'h0002_0304, 32'h3001_0302};
  int                    mTab[8] = '{256, 256, 256, 512, 0, 0, 192, 256};
  int                    uTab[8] = '{256, 128, 64, 512, 0, 0, 192, 0};

  ccm_clock_ctrl #(.PERIPH_IMPL(IMPL)) dut_u (
    .sys_clk      (sys_clk),
    .rstn         (rstn),
    .busReq       (busReq),
    .rdData       (rdData),
    .slowClkPin   (slowClkPin),
    .oscInputPin  (oscInputPin),
    .oscOutputPin (oscOutputPin),
    .periphClkEn  (periphClkEn),
    .masterClkTick(masterClkTick),
    .usbClkTick   (usbClkTick)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Slow tick every 16 cycles, main edge every 4
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    slowClkPin <= cyc[3];
    oscInputPin <= cyc[1];
  end

  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    @(posedge sys_clk);
    busReq <= '{a, dv, 1'b1, 1'b0};
    @(posedge sys_clk);
    busReq.wrStb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge sys_clk);
    busReq.rdStb <= 1'b0;
    #1 v = rdData;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  // Tick counts drift with sync phase, so compare within a margin
  task automatic inr(input string n, input int e, input int s);
    checks++;
    if (s < e - e / 32 - 4 || s > e + e / 32 + 4) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", n, e, s);
    end
  endtask

  task automatic cnt(input int n);
    m = 0;
    u = 0;
    repeat (n) begin
      @(posedge sys_clk);
      m += int'(masterClkTick === 1'b1);
      u += int'(usbClkTick === 1'b1);
    end
  endtask

  task automatic poll(input int b);
    t = 0;
    rd(ccm_pkg::STATUS_OFS);
    while (v[b] !== 1'b1 && t < 600) begin
      rd(ccm_pkg::STATUS_OFS);
      t += 2;
    end
  endtask

  // Place the next write against the slow tick phase, so a count of N slow
  // cycles is N whole periods rather than a partial first one
  task automatic align(input int ph);
    do begin
      @(posedge sys_clk);
    end while (cyc % 16 != ph);
  endtask

  task automatic wrap_up;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end

  initial begin
    rstn = 1'b0;
    busReq = '0;
    cyc = 0;
    slowClkPin = 1'b0;
    oscInputPin = 1'b0;
    seed = 7;
    fail_count = 0;
    checks = 0;
    pce = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(ccm_pkg::STATUS_OFS);
    chk("status", 32'h8, v);
    rd(ccm_pkg::PLL_CFG_OFS);
    chk("pll", 32'h3F00, v);
    rd(8'h1C);
    chk("unmapped", 32'h0, v);
    // ************************************************************
    // Peripheral clocks
    // ************************************************************
    for (int i = 0; i < 12; i++) begin
      d = xs();
      wr(ccm_pkg::PERIPH_EN_OFS, d);
      pce |= d & IMPL;
      d = xs();
      wr(ccm_pkg::PERIPH_DIS_OFS, d);
      pce &= ~d;
      rd(ccm_pkg::PERIPH_STAT_OFS);
      chk("pstat", pce, v);
      chk("clkEn", pce, periphClkEn);
    end
    // ************************************************************
    // Oscillator and measurement
    // ************************************************************
    wr(ccm_pkg::OSC_CTRL_OFS, 32'h2);
    rd(ccm_pkg::STATUS_OFS);
    chk("stable", 1, v[0]);
    wr(ccm_pkg::OSC_CTRL_OFS, 32'h0);
    rd(ccm_pkg::STATUS_OFS);
    chk("stable", 0, v[0]);
    wr(ccm_pkg::OSC_CTRL_OFS, 32'h1);
    rd(ccm_pkg::MAIN_FREQ_OFS);
    chk("ready", 0, v[16]);
    chk("drive", 1, oscOutputPin);
    repeat (20 * 16) @(posedge sys_clk);
    rd(ccm_pkg::MAIN_FREQ_OFS);
    chk("ready", 1, v[16]);
    inr("freq", 16 * 16 / 4, int'(v[15:0]));
    wr(ccm_pkg::OSC_CTRL_OFS, 32'h0);
    align(8);
    wr(ccm_pkg::OSC_CTRL_OFS, 32'h0201);
    poll(ccm_pkg::STAT_STABLE_BIT);
    inr("startup", 2 * 8 * 16, t);
    chk("stable", 1, v[0]);
    wr(ccm_pkg::OSC_CTRL_OFS, 32'h2);
    // ************************************************************
    // Master source, prescaler and PLL
    // ************************************************************
    for (int p = 0; p < 8; p++) begin
      wr(ccm_pkg::MASTER_SEL_OFS, 32'(p * 4 + 1));
      cnt(1024);
      inr("presc", p == 7 ? 0 : 256 >> p, m);
    end
    wr(ccm_pkg::MASTER_SEL_OFS, 32'h0);
    cnt(1024);
    inr("slow", 64, m);
    wr(ccm_pkg::MASTER_SEL_OFS, 32'h2);
    cnt(512);
    inr("rsvd", 0, m);
    wr(ccm_pkg::PLL_CFG_OFS, 32'h3000_C302);
    rd(ccm_pkg::PLL_CFG_OFS);
    chk("pllrw", 32'h3000_C302, v);
    align(9);
    wr(ccm_pkg::PLL_CFG_OFS, 32'h1001_0302);
    poll(ccm_pkg::STAT_LOCK_BIT);
    inr("lock", 3 * 16, t);
    wr(ccm_pkg::MASTER_SEL_OFS, 32'h3);
    for (int k = 0; k < 8; k++) begin
      wr(ccm_pkg::PLL_CFG_OFS, pllTab[k]);
      repeat (100) @(posedge sys_clk);
      cnt(1024);
      inr("pll", mTab[k], m);
      inr("usb", uTab[k], u);
    end
    wrap_up();
  end
endmodule

bind ccm_clock_ctrl ccm_clock_ctrl_props chk_u (
  .sys_clk      (sys_clk),
  .rstn         (rstn),
  .busReq       (busReq),
  .rdData       (rdData),
  .slowClkPin   (slowClkPin),
  .oscInputPin  (oscInputPin),
  .oscOutputPin (oscOutputPin),
  .periphClkEn  (periphClkEn),
  .masterClkTick(masterClkTick),
  .usbClkTick   (usbClkTick)
);
